//--- sru_pkg.sv
// constants, carriers and state types shared by the status reporting unit
package sru_pkg;

    // ****************************************************************
    // register byte offsets on the wishbone bus
    // ****************************************************************
    localparam logic [7:0] SRU_OFF_STB   = 8'h00;
    localparam logic [7:0] SRU_OFF_SRE   = 8'h04;
    localparam logic [7:0] SRU_OFF_QCOND = 8'h08;
    localparam logic [7:0] SRU_OFF_QEVT  = 8'h0C;
    localparam logic [7:0] SRU_OFF_QEN   = 8'h10;
    localparam logic [7:0] SRU_OFF_ESR   = 8'h14;
    localparam logic [7:0] SRU_OFF_ESE   = 8'h18;
    localparam logic [7:0] SRU_OFF_CMD   = 8'h1C;
    localparam logic [7:0] SRU_OFF_PSC   = 8'h20;
    localparam logic [7:0] SRU_OFF_OPEN  = 8'h24;

    // ****************************************************************
    // status byte bit positions
    // ****************************************************************
    localparam int unsigned SRU_STB_EAV = 2;
    localparam int unsigned SRU_STB_QSB = 3;
    localparam int unsigned SRU_STB_MAV = 4;
    localparam int unsigned SRU_STB_ESB = 5;
    localparam int unsigned SRU_STB_MSS = 6;
    localparam int unsigned SRU_STB_OSB = 7;

    // ****************************************************************
    // standard event bits and valid masks
    // ****************************************************************
    localparam int unsigned SRU_ESR_OPC = 0;
    localparam int unsigned SRU_ESR_PON = 7;
    localparam logic [7:0]  SRU_ESR_VALID = 8'hBD;
    localparam logic [7:0]  SRU_ESR_EXT   = 8'h3C;
    localparam logic [15:0] SRU_QUES_VALID = 16'h0321;

    // ****************************************************************
    // command register bits
    // ****************************************************************
    localparam int unsigned SRU_CMD_CLS  = 0;
    localparam int unsigned SRU_CMD_PRES = 1;
    localparam int unsigned SRU_CMD_OPC  = 2;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic        SRU_PSC_RST    = 1'b1;
    localparam logic [7:0]  SRU_MASK8_RST  = 8'h00;
    localparam logic [15:0] SRU_MASK16_RST = 16'h0000;
    localparam logic [31:0] SRU_WORD_RST   = 32'h0000_0000;

    // ****************************************************************
    // carriers and states
    // ****************************************************************
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } sru_wb_req_t;

    typedef struct packed {
        logic       psc_we;
        logic       psc_d;
        logic       sre_we;
        logic [7:0] sre_d;
        logic       ese_we;
        logic [7:0] ese_d;
        logic       por_clr;
    } sru_nv_wr_t;

    typedef enum logic [1:0] {
        SRU_OPC_IDLE = 2'b00,
        SRU_OPC_WAIT = 2'b01
    } sru_opc_state_t;

endpackage

//--- sru_nvstore.sv
// retained store for the power-on clear setting and two enable masks
`timescale 1ns/1ps
`default_nettype none

module sru_nvstore
(
    // clock and store initialisation
    input  wire logic               i_clk_sys,
    input  wire logic               i_nv_init,
    // write side
    input  wire sru_pkg::sru_nv_wr_t i_wr,
    // retained values
    output logic                    o_psc,
    output logic [7:0]              o_sre,
    output logic [7:0]              o_ese
);
    import sru_pkg::*;

    // not cleared by the system reset, so contents survive a power cycle except masks cleared by por_clr
    always_ff @(posedge i_clk_sys)
    begin
        if (i_nv_init)
            o_psc <= SRU_PSC_RST;
        else if (i_wr.psc_we)
            o_psc <= i_wr.psc_d;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_nv_init || i_wr.por_clr)
            o_sre <= SRU_MASK8_RST;
        else if (i_wr.sre_we)
            o_sre <= i_wr.sre_d;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_nv_init || i_wr.por_clr)
            o_ese <= SRU_MASK8_RST;
        else if (i_wr.ese_we)
            o_ese <= i_wr.ese_d;
    end

endmodule
`default_nettype wire

//--- sru_top.sv
// status reporting unit: status byte, questionable data and standard event groups
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - status byte read returns the poll summary and never clears bit 6.
// - bit 6 summarises status byte bits selected by the request enable.
// - a selected status byte bit rising from 0 to 1 raises a request.
// - clear status zeroes event bits but keeps every enable mask.
// - status preset leaves the request enable mask untouched.
// - questionable condition is read-only; reading it clears nothing.
// - questionable event bits latch until read or cleared by clear status.
// - enabled questionable events form the questionable summary bit.
// - every enable mask reads back the value last written; request enable bit 6 always reads 0.
// - standard event bits latch; read or clear status clears them.
// - enabled standard events form status byte bit 5.
// - clear status clears all events, the error queue and pending completion.
// - status preset zeroes questionable and operation enable masks.
// - power-on clear setting 1 clears event enable and request enable at power-up.
// - with the setting at 0 the event enable and request enable masks survive power cycles.
// - completion bit 0 sets only after all earlier commands have finished.
// - questionable enable always clears at power-up.
// - standard event weights 1,4,8,16,32,128; weights 2 and 64 read zero.
// - questionable weights 1,32,256,512; all other bits read zero.
module sru_top
(
    // clock and reset
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_nv_init,
    // wishbone slave
    input  wire sru_pkg::sru_wb_req_t i_wb,
    output logic                      o_wb_ack,
    output logic [31:0]               o_wb_dat,
    // status sources
    input  wire logic [15:0]          i_ques_cond,
    input  wire logic [7:0]           i_std_evt,
    input  wire logic [15:0]          i_oper_cond,
    input  wire logic                 i_err_queue_nonempty,
    input  wire logic                 i_msg_avail,
    input  wire logic                 i_cmds_done,
    // status outputs
    output logic                      o_srq,
    output logic                      o_mss,
    output logic                      o_err_queue_clr,
    output logic                      o_opc_pending
);
    import sru_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] merge_sel(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                res[8*b +: 8] = new_w[8*b +: 8];
        end
        return res;
    endfunction

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [15:0]     qevt_reg;
    logic [15:0]     qevt_next;
    logic [15:0]     qen_reg;
    logic [15:0]     qcond_prev_reg;
    logic [15:0]     open_reg;
    logic [7:0]      esr_reg;
    logic [7:0]      esr_next;
    logic [7:0]      stb_prev_reg;
    logic            por_pend_reg;
    sru_opc_state_t  opc_reg;
    sru_opc_state_t  opc_next;
    logic            psc_q;
    logic [7:0]      sre_q;
    logic [7:0]      ese_q;
    sru_nv_wr_t      nv_wr;

    logic            access;
    logic            wr_acc;
    logic            rd_acc;
    logic [31:0]     wdat;
    logic [7:0]      cmd_w;
    logic            cls;
    logic            pres;
    logic            opc_set;
    logic [7:0]      stb_sum;
    logic            mss;
    logic [31:0]     rdat;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    // one access per request: ack blocks a second strobe in the ack cycle
    assign access = i_wb.cyc && i_wb.stb && !o_wb_ack;
    assign wr_acc = access && i_wb.we;
    assign rd_acc = access && !i_wb.we;
    assign wdat   = merge_sel(SRU_WORD_RST, i_wb.dat, i_wb.sel);
    assign cmd_w  = (wr_acc && hit(i_wb.adr, SRU_OFF_CMD)) ? wdat[7:0] : SRU_MASK8_RST;
    assign cls    = cmd_w[SRU_CMD_CLS];
    assign pres   = cmd_w[SRU_CMD_PRES];

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            o_wb_ack <= 1'b0;
        else
            o_wb_ack <= access;
    end

    // ****************************************************************
    // power-on handling
    // ****************************************************************
    // setting sampled in every cycle inside the reset and in the first cycle after release
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            por_pend_reg <= 1'b1;
        else
            por_pend_reg <= 1'b0;
    end

    always_comb
    begin
        nv_wr         = '0;
        nv_wr.por_clr = por_pend_reg && psc_q;
        nv_wr.psc_we  = wr_acc && hit(i_wb.adr, SRU_OFF_PSC) && i_wb.sel[0];
        nv_wr.psc_d   = i_wb.dat[0];
        nv_wr.sre_we  = wr_acc && hit(i_wb.adr, SRU_OFF_SRE) && i_wb.sel[0];
        nv_wr.sre_d   = i_wb.dat[7:0] & ~(8'h01 << SRU_STB_MSS);
        nv_wr.ese_we  = wr_acc && hit(i_wb.adr, SRU_OFF_ESE) && i_wb.sel[0];
        nv_wr.ese_d   = i_wb.dat[7:0];
    end

    sru_nvstore u_nvstore
    (
        .i_clk_sys (i_clk_sys),
        .i_nv_init (i_nv_init),
        .i_wr      (nv_wr),
        .o_psc     (psc_q),
        .o_sre     (sre_q),
        .o_ese     (ese_q)
    );

    // ****************************************************************
    // questionable data group
    // ****************************************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            qcond_prev_reg <= SRU_MASK16_RST;
        else
            qcond_prev_reg <= i_ques_cond & SRU_QUES_VALID;
    end

    always_comb
    begin
        qevt_next = qevt_reg;
        // read or clear status drops latched bits
        if (cls || (rd_acc && hit(i_wb.adr, SRU_OFF_QEVT)))
            qevt_next = SRU_MASK16_RST;
        // only weighted bits latch; set wins over clear
        qevt_next = qevt_next | (i_ques_cond & ~qcond_prev_reg & SRU_QUES_VALID);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            qevt_reg <= SRU_MASK16_RST;
        else
            qevt_reg <= qevt_next;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            qen_reg <= SRU_MASK16_RST;
        else if (pres)
            qen_reg <= SRU_MASK16_RST;
        else if (wr_acc && hit(i_wb.adr, SRU_OFF_QEN))
            qen_reg <= 16'(merge_sel({16'h0000, qen_reg}, i_wb.dat, i_wb.sel));
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            open_reg <= SRU_MASK16_RST;
        else if (pres)
            open_reg <= SRU_MASK16_RST;
        else if (wr_acc && hit(i_wb.adr, SRU_OFF_OPEN))
            open_reg <= 16'(merge_sel({16'h0000, open_reg}, i_wb.dat, i_wb.sel));
    end

    // ****************************************************************
    // operation complete sequencing
    // ****************************************************************
    always_comb
    begin
        opc_next = opc_reg;
        opc_set  = 1'b0;
        case (opc_reg)
            SRU_OPC_IDLE:
            begin
                if (cmd_w[SRU_CMD_OPC])
                    opc_next = SRU_OPC_WAIT;
            end
            SRU_OPC_WAIT:
            begin
                if (cls && !cmd_w[SRU_CMD_OPC])
                    opc_next = SRU_OPC_IDLE;
                // set only once earlier commands are done
                else if (!cls && i_cmds_done)
                begin
                    opc_set  = 1'b1;
                    opc_next = cmd_w[SRU_CMD_OPC] ? SRU_OPC_WAIT : SRU_OPC_IDLE;
                end
            end
            default:
                opc_next = SRU_OPC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            opc_reg <= SRU_OPC_IDLE;
        else
            opc_reg <= opc_next;
    end

    // ****************************************************************
    // standard event group
    // ****************************************************************
    always_comb
    begin
        esr_next = esr_reg;
        // read or clear status drops latched bits
        if (cls || (rd_acc && hit(i_wb.adr, SRU_OFF_ESR)))
            esr_next = SRU_MASK8_RST;
        // external events only on weights 4..32
        esr_next = esr_next | (i_std_evt & SRU_ESR_EXT);
        esr_next[SRU_ESR_OPC] = esr_next[SRU_ESR_OPC] | opc_set;
        esr_next[SRU_ESR_PON] = esr_next[SRU_ESR_PON] | por_pend_reg;
        esr_next = esr_next & SRU_ESR_VALID;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            esr_reg <= SRU_MASK8_RST;
        else
            esr_reg <= esr_next;
    end

    // ****************************************************************
    // status byte and service request
    // ****************************************************************
    always_comb
    begin
        stb_sum              = SRU_MASK8_RST;
        stb_sum[SRU_STB_EAV] = i_err_queue_nonempty;
        stb_sum[SRU_STB_QSB] = |(qevt_reg & qen_reg);
        stb_sum[SRU_STB_MAV] = i_msg_avail;
        stb_sum[SRU_STB_ESB] = |(esr_reg & ese_q);
        stb_sum[SRU_STB_OSB] = |(i_oper_cond & open_reg);
    end

    assign mss = |(stb_sum & sre_q & ~(8'h01 << SRU_STB_MSS));

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            stb_prev_reg <= SRU_MASK8_RST;
        else
            stb_prev_reg <= stb_sum;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            o_srq <= 1'b0;
        else
            o_srq <= |(stb_sum & ~stb_prev_reg & sre_q);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            o_mss <= 1'b0;
        else
            o_mss <= mss;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            o_err_queue_clr <= 1'b0;
        else
            o_err_queue_clr <= cls;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            o_opc_pending <= 1'b0;
        else
            o_opc_pending <= (opc_next == SRU_OPC_WAIT);
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // clear status touches no enable mask
    always_comb
    begin
        rdat = SRU_WORD_RST;
        case (i_wb.adr[7:2])
            SRU_OFF_STB[7:2]:   rdat[7:0]  = stb_sum | ({7'h00, mss} << SRU_STB_MSS);
            SRU_OFF_SRE[7:2]:   rdat[7:0]  = sre_q;
            SRU_OFF_QCOND[7:2]: rdat[15:0] = i_ques_cond & SRU_QUES_VALID;
            SRU_OFF_QEVT[7:2]:  rdat[15:0] = qevt_reg;
            SRU_OFF_QEN[7:2]:   rdat[15:0] = qen_reg;
            SRU_OFF_ESR[7:2]:   rdat[7:0]  = esr_reg;
            SRU_OFF_ESE[7:2]:   rdat[7:0]  = ese_q;
            // setting readable as 0 or 1
            SRU_OFF_PSC[7:2]:   rdat[0]    = psc_q;
            SRU_OFF_OPEN[7:2]:  rdat[15:0] = open_reg;
            default:            rdat       = SRU_WORD_RST;
        endcase
    end

    // data held until the next read so it stays stable with ack
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            o_wb_dat <= SRU_WORD_RST;
        else if (rd_acc)
            o_wb_dat <= rdat;
    end

endmodule
`default_nettype wire

//--- sru_checker.sv
// concurrent assertions on the status reporting unit ports
`timescale 1ns/1ps
`default_nettype none

module sru_checker
(
    // clock and reset
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_sys_rst,
    // wishbone
    input  wire sru_pkg::sru_wb_req_t i_wb,
    input  wire logic                 o_wb_ack,
    input  wire logic [31:0]          o_wb_dat,
    // status
    input  wire logic                 i_cmds_done,
    input  wire logic                 o_srq,
    input  wire logic                 o_mss,
    input  wire logic                 o_err_queue_clr,
    input  wire logic                 o_opc_pending
);
    import sru_pkg::*;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    logic take;
    assign take = i_wb.cyc && i_wb.stb && !o_wb_ack;

    // ****************************************************************
    // bus steps
    // ****************************************************************
    sequence s_rd(logic [7:0] a);
        take && !i_wb.we && i_wb.adr == a;
    endsequence

    sequence s_cmd(int b);
        take && i_wb.we && i_wb.sel[0] && i_wb.adr == SRU_OFF_CMD && i_wb.dat[b];
    endsequence

    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (take |=> o_wb_ack)
        else $error("no ack one cycle after request");
    unmapped_read_a: assert property (take && !i_wb.we && i_wb.adr > SRU_OFF_OPEN
        |=> o_wb_dat == 32'h0) else $error("unmapped read not zero");
    sre_reserved_a: assert property (s_rd(SRU_OFF_SRE)
        |=> o_wb_dat[31:8] == 24'h0 && !o_wb_dat[6]) else $error("request enable bit 6 set");
    esr_weights_a: assert property (s_rd(SRU_OFF_ESR)
        |=> (o_wb_dat & ~{24'h0, SRU_ESR_VALID}) == 32'h0) else $error("unused event bit set");
    ques_weights_a: assert property ((s_rd(SRU_OFF_QCOND) or s_rd(SRU_OFF_QEVT))
        |=> (o_wb_dat & ~{16'h0, SRU_QUES_VALID}) == 32'h0) else $error("unused ques bit set");
    err_clear_a: assert property (s_cmd(SRU_CMD_CLS)
        |=> o_err_queue_clr ##1 !o_err_queue_clr) else $error("error queue clear pulse wrong");
    opc_arm_a: assert property (s_cmd(SRU_CMD_OPC) |=> o_opc_pending)
        else $error("completion not armed");
    opc_fire_a: assert property (o_opc_pending && i_cmds_done && !take
        |=> !o_opc_pending) else $error("completion not taken when done");
    opc_hold_a: assert property (o_opc_pending && !i_cmds_done && !take
        |=> o_opc_pending) else $error("completion dropped early");
    srq_summary_a: assert property (o_srq |-> o_mss)
        else $error("request without summary");
endmodule

`default_nettype wire

//--- sru_host_model.sv
// wishbone host that issues status commands to the unit
`timescale 1ns/1ps
`default_nettype none

module sru_host_model
(
    // clock
    input  wire logic            i_clk_sys,
    // answer
    input  wire logic            i_wb_ack,
    input  wire logic [31:0]     i_wb_dat,
    // request
    output var sru_pkg::sru_wb_req_t o_wb
);
    import sru_pkg::*;

    initial o_wb = '0;

    // released lines show the inverse so a stale value is never mistaken for data
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rdat);
        @(posedge i_clk_sys);
        o_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        // no local limit: only the bench watchdog ends a wait for ack
        do
        begin
            @(posedge i_clk_sys);
        end
        while (i_wb_ack !== 1'b1);
        rdat = i_wb_dat;
        o_wb <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~wd};
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] unused;
        xfer(1'b1, adr, dat, unused);
    endtask

    task automatic rd(input logic [7:0] adr, output logic [31:0] dat);
        xfer(1'b0, adr, 32'h0, dat);
    endtask
endmodule

`default_nettype wire

//--- status_reporting_unit_tb_top.sv
// self-checking bench for the status reporting unit
`timescale 1ns/1ps
`default_nettype none

module status_reporting_unit_tb_top;
    import sru_pkg::*;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        nv_init = 1'b1;
    logic [15:0] ques = 16'h0;
    logic [7:0]  sevt = 8'h0;
    logic        err = 1'b0;
    logic        msg = 1'b0;
    logic        done = 1'b0;
    sru_wb_req_t wb;
    logic        ack, srq, mss, eclr, opc;
    logic [31:0] rdat, v;
    int          fails = 0;
    int          tests_run = 0;
    int          srq_n = 0;
    int          eclr_n = 0;

    initial
    begin
        forever #5 clk = ~clk;
    end

    // operation condition tied low: its summary bit is outside these tests
    sru_top i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_nv_init(nv_init), .i_wb(wb),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_ques_cond(ques), .i_std_evt(sevt),
        .i_oper_cond(16'h0), .i_err_queue_nonempty(err), .i_msg_avail(msg),
        .i_cmds_done(done), .o_srq(srq), .o_mss(mss), .o_err_queue_clr(eclr),
        .o_opc_pending(opc));
    sru_host_model i_host (.i_clk_sys(clk), .i_wb_ack(ack), .i_wb_dat(rdat), .o_wb(wb));

    always @(posedge clk)
    begin
        if (srq === 1'b1) srq_n++;
        if (eclr === 1'b1) eclr_n++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
        i_host.rd(a, v);
        chk(v, exp, what);
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk);
        fails++;
        results();
    end

    initial
    begin
        @(posedge clk);
        nv_init <= 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rc(SRU_OFF_PSC, 32'h1, "psc default");
        rc(SRU_OFF_ESR, 32'h80, "esr power on");
        rc(SRU_OFF_ESR, 32'h0, "esr read clear");
        rc(SRU_OFF_QEN, 32'h0, "qen reset");
        rc(8'h3C, 32'h0, "unmapped");
        $display("test power_on done");
        i_host.wr(SRU_OFF_SRE, 32'hFF);
        i_host.wr(SRU_OFF_ESE, 32'h3C);
        i_host.wr(SRU_OFF_QEN, 32'h321);
        i_host.wr(SRU_OFF_OPEN, 32'hF0);
        rc(SRU_OFF_SRE, 32'hBF, "sre readback");
        rc(SRU_OFF_ESE, 32'h3C, "ese readback");
        rc(SRU_OFF_QEN, 32'h321, "qen readback");
        rc(SRU_OFF_OPEN, 32'hF0, "open readback");
        chk(32'(srq_n), 32'h0, "srq on enable");
        $display("test enables done");
        err <= 1'b1;
        msg <= 1'b1;
        repeat (3) @(posedge clk);
        rc(SRU_OFF_STB, 32'h54, "stb err msg");
        chk(32'(srq_n), 32'h1, "srq err msg");
        chk({31'h0, mss}, 32'h1, "mss high");
        err <= 1'b0;
        msg <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'h0, mss}, 32'h0, "mss low");
        $display("test status_byte done");
        ques <= 16'hFFFF;
        repeat (3) @(posedge clk);
        rc(SRU_OFF_QCOND, 32'h321, "qcond");
        rc(SRU_OFF_QCOND, 32'h321, "qcond kept");
        rc(SRU_OFF_STB, 32'h48, "stb ques");
        rc(SRU_OFF_STB, 32'h48, "stb bit6 kept");
        chk(32'(srq_n), 32'h2, "srq ques");
        rc(SRU_OFF_QEVT, 32'h321, "qevt");
        rc(SRU_OFF_QEVT, 32'h0, "qevt read clear");
        repeat (2) @(posedge clk);
        rc(SRU_OFF_STB, 32'h0, "stb ques gone");
        $display("test questionable done");
        sevt <= 8'hFF;
        @(posedge clk);
        sevt <= 8'h00;
        repeat (3) @(posedge clk);
        rc(SRU_OFF_STB, 32'h60, "stb std");
        rc(SRU_OFF_ESR, 32'h3C, "esr latched");
        rc(SRU_OFF_ESR, 32'h0, "esr read clear");
        $display("test std_event done");
        ques <= 16'h0;
        sevt <= 8'h3C;
        @(posedge clk);
        sevt <= 8'h00;
        ques <= 16'hFFFF;
        repeat (3) @(posedge clk);
        i_host.wr(SRU_OFF_CMD, 32'h1);
        @(posedge clk);
        chk(32'(eclr_n), 32'h1, "error queue clear");
        rc(SRU_OFF_ESR, 32'h0, "esr cls");
        rc(SRU_OFF_QEVT, 32'h0, "qevt cls");
        rc(SRU_OFF_ESE, 32'h3C, "ese after cls");
        rc(SRU_OFF_SRE, 32'hBF, "sre after cls");
        rc(SRU_OFF_QEN, 32'h321, "qen after cls");
        i_host.wr(SRU_OFF_CMD, 32'h2);
        rc(SRU_OFF_QEN, 32'h0, "qen preset");
        rc(SRU_OFF_OPEN, 32'h0, "open preset");
        rc(SRU_OFF_SRE, 32'hBF, "sre preset");
        $display("test clear_preset done");
        i_host.wr(SRU_OFF_CMD, 32'h4);
        repeat (3) @(posedge clk);
        chk({31'h0, opc}, 32'h1, "opc armed");
        rc(SRU_OFF_ESR, 32'h0, "esr before done");
        done <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, opc}, 32'h0, "opc taken");
        rc(SRU_OFF_ESR, 32'h1, "esr complete");
        done <= 1'b0;
        i_host.wr(SRU_OFF_CMD, 32'h4);
        i_host.wr(SRU_OFF_CMD, 32'h1);
        done <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, opc}, 32'h0, "opc cancelled");
        rc(SRU_OFF_ESR, 32'h0, "esr cancelled");
        done <= 1'b0;
        $display("test completion done");
        i_host.wr(SRU_OFF_PSC, 32'h0);
        i_host.wr(SRU_OFF_QEN, 32'h21);
        do_reset();
        rc(SRU_OFF_PSC, 32'h0, "psc kept");
        rc(SRU_OFF_SRE, 32'hBF, "sre retained");
        rc(SRU_OFF_ESE, 32'h3C, "ese retained");
        rc(SRU_OFF_QEN, 32'h0, "qen power up");
        i_host.wr(SRU_OFF_PSC, 32'h1);
        do_reset();
        rc(SRU_OFF_SRE, 32'h0, "sre cleared");
        rc(SRU_OFF_ESE, 32'h0, "ese cleared");
        $display("test power_clear done");
        results();
    end
endmodule

bind sru_top sru_checker i_chk (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_wb(i_wb),
    .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_cmds_done(i_cmds_done), .o_srq(o_srq),
    .o_mss(o_mss), .o_err_queue_clr(o_err_queue_clr), .o_opc_pending(o_opc_pending));

`default_nettype wire
